// ==== core/pin_sync.v ====
`timescale 1ns/10ps

module pin_sync #(
  parameter INIT = 1'b0
) (
  input  wire clk,
  input  wire reset,
  input  wire din,
  output reg  dout
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // a change counts once the second and third stages agree
  always @(posedge clk) begin
    if (reset) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      dout <= INIT;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end

endmodule

// ==== core/temp_sensor_ctrl.v ====
// Notes on behaviour
// - standby pin low or halt config bit high stops the converter.
// - standby keeps registers and the serial interface fully working.
// - in hardware standby a one-shot command starts nothing.
// - in software standby a one-shot still runs one full conversion.
// - standby pin low overrides every software conversion request.
// - standby mid-conversion aborts it; results keep their old values.
// - one conversion of both channels lasts 125 ms; idle in between.
// - one slave address serves every register of both channels.
// - only Write, Read, Send and Receive Byte transactions are used.
// - write byte is address+write, command, data; each byte acknowledged.
// - read byte: address, command, repeated start, address+read, data.
// - send byte carries address and command only; issues one-shot.
// - receive byte returns register chosen by the last command byte.
// - temperatures are 8-bit two's complement, 1 degree, MSB first.
// - add half a degree, truncate, saturate at +127 and -65.
// - four limits; alarm when at/above high or at/below low.
// - high limits reset to 7fh, low limits reset to c9h.
// - diode open detector sampled at each conversion start.
// - no diode fault reported before the first conversion begins.
// - shorted remote input reads as zero.
// - alert response answer is latched address with bit 0 set.
// - command bytes 00h to 0fh select registers and one-shot.
// - config bit 7 masks alerts, bit 6 halts; both reset low.
// - status read clears flags unless fault persists; alert stays.
// - alert latch clears only after a won alert response reply.
`timescale 1ns/10ps
`include "temp_sensor_regs.vh"

module temp_sensor_ctrl #(
  parameter CONV_CYCLES      = `CONV_CYCLES,
  parameter RATE_BASE_CYCLES = `RATE_BASE_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_drive_n,
  output reg         alert_out,
  output reg         alert_drive_n,
  input  wire        standby_pin_n,
  input  wire        address_strap_0,
  input  wire        address_strap_1,
  input  wire        diode_open,
  input  wire        remote_short,
  input  wire [10:0] local_temp_quarter,
  input  wire [10:0] remote_temp_quarter,
  output reg         busy
);

  localparam S_IDLE  = 3'd0;
  localparam S_RX    = 3'd1;
  localparam S_ACK   = 3'd2;
  localparam S_TX    = 3'd3;
  localparam S_TXACK = 3'd4;
  localparam S_WAIT  = 3'd5;
  localparam K_ADDR  = 2'd0;
  localparam K_CMD   = 2'd1;
  localparam K_DATA  = 2'd2;

  wire scl_s;
  wire sda_s;
  wire standby_pin_n_n_s;
  wire strap0_s;
  wire strap1_s;
  wire open_s;
  wire short_s;

  pin_sync #(.INIT(1'b1)) u_scl (.clk(clk), .reset(reset), .din(scl_in),
    .dout(scl_s));
  pin_sync #(.INIT(1'b1)) u_sda (.clk(clk), .reset(reset), .din(sda_in),
    .dout(sda_s));
  pin_sync #(.INIT(1'b1)) u_standby_pin_n (.clk(clk), .reset(reset),
    .din(standby_pin_n), .dout(standby_pin_n_n_s));
  pin_sync #(.INIT(1'b0)) u_st0 (.clk(clk), .reset(reset),
    .din(address_strap_0), .dout(strap0_s));
  pin_sync #(.INIT(1'b0)) u_st1 (.clk(clk), .reset(reset),
    .din(address_strap_1), .dout(strap1_s));
  pin_sync #(.INIT(1'b0)) u_open (.clk(clk), .reset(reset),
    .din(diode_open), .dout(open_s));
  pin_sync #(.INIT(1'b0)) u_short (.clk(clk), .reset(reset),
    .din(remote_short), .dout(short_s));

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg  [7:0]  local_temp_r;
  reg  [7:0]  remote_temp_r;
  reg  [7:0]  config_r;
  reg  [7:0]  rate_r;
  reg  [7:0]  loc_high_r;
  reg  [7:0]  loc_low_r;
  reg  [7:0]  rem_high_r;
  reg  [7:0]  rem_low_r;
  reg  [4:0]  flags_r;
  reg         open_r;
  reg         alert_r;
  reg  [7:0]  cmd_r;
  reg  [6:0]  own_addr_r;
  reg  [2:0]  strap_cnt_r;
  reg  [31:0] conv_cnt_r;
  reg  [31:0] rate_cnt_r;
  reg         oneshot_r;

  reg         wr_stb_r;
  reg  [7:0]  wr_data_r;
  reg         oneshot_stb_r;
  reg         stat_clr_stb_r;
  reg         ara_ok_stb_r;

  // +1/2 degree then floor; input is quarter degrees
  function [7:0] encode_temp;
    input [10:0] q;
    reg signed [11:0] s;
    begin
      s = $signed({q[10], q}) + 12'sd2;
      if (s >= 12'sd512)
        encode_temp = 8'h7f;
      else if (s < -12'sd260)
        encode_temp = 8'hbf;
      else
        encode_temp = s[9:2];
    end
  endfunction

  // {at or above high, at or below low}
  function [1:0] limit_check;
    input [7:0] t;
    input [7:0] hi;
    input [7:0] lo;
    begin
      limit_check = {$signed(t) >= $signed(hi),
                     $signed(t) <= $signed(lo)};
    end
  endfunction

  wire        hw_standby_pin_n   = ~standby_pin_n_n_s;
  wire        halt      = config_r[`CFG_HALT_BIT];
  wire [7:0]  loc_new   = encode_temp(local_temp_quarter);
  wire [7:0]  rem_new   = short_s ? 8'h00 :
                          encode_temp(remote_temp_quarter);
  wire [2:0]  rate_sel  = (rate_r > `RATE_MAX) ? 3'h7 : rate_r[2:0];
  wire [31:0] interval  = RATE_BASE_CYCLES >> rate_sel;
  wire        conv_done = busy && (conv_cnt_r == CONV_CYCLES - 1);
  wire        halt_wr   = wr_stb_r && (cmd_r == `CMD_WR_CONFIG) &&
                          wr_data_r[`CFG_HALT_BIT];
  wire        timer_due = ~busy && ~hw_standby_pin_n && ~halt &&
                          (rate_cnt_r >= interval);
  wire        os_start  = oneshot_stb_r && ~hw_standby_pin_n;
  wire        conv_abort = busy && (hw_standby_pin_n || halt_wr ||
                           (halt && ~oneshot_r));
  wire        conv_start = ~hw_standby_pin_n && (os_start || timer_due);
  wire        load_evt  = conv_done && ~conv_abort && ~os_start;

  wire [4:0]  cond_now  = {limit_check(local_temp_r, loc_high_r, loc_low_r),
                           limit_check(remote_temp_r, rem_high_r, rem_low_r),
                           open_r};
  wire [4:0]  set_vec   = {{4{load_evt}} &
                           {limit_check(loc_new, loc_high_r, loc_low_r),
                            limit_check(rem_new, rem_high_r, rem_low_r)},
                           conv_start & open_s};
  wire [7:0]  status    = {busy, flags_r, 2'b00};

  reg  [7:0]  read_mux;
  always @* begin
    case (cmd_r)
      `CMD_RD_LOCAL:    read_mux = local_temp_r;
      `CMD_RD_REMOTE:   read_mux = remote_temp_r;
      `CMD_RD_STATUS:   read_mux = status;
      `CMD_RD_CONFIG:   read_mux = config_r;
      `CMD_RD_RATE:     read_mux = rate_r;
      `CMD_RD_LOC_HIGH: read_mux = loc_high_r;
      `CMD_RD_LOC_LOW:  read_mux = loc_low_r;
      `CMD_RD_REM_HIGH: read_mux = rem_high_r;
      `CMD_RD_REM_LOW:  read_mux = rem_low_r;
      default:          read_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter sequencing and register file

  always @(posedge clk) begin
    if (reset) begin
      busy          <= 1'b0;
      conv_cnt_r    <= 32'h0;
      rate_cnt_r    <= 32'hffffffff;
      oneshot_r     <= 1'b0;
      local_temp_r  <= `RST_TEMP;
      remote_temp_r <= `RST_TEMP;
      config_r      <= `RST_CONFIG;
      rate_r        <= `RST_RATE;
      loc_high_r    <= `RST_HIGH_LIMIT;
      rem_high_r    <= `RST_HIGH_LIMIT;
      loc_low_r     <= `RST_LOW_LIMIT;
      rem_low_r     <= `RST_LOW_LIMIT;
      flags_r       <= 5'h00;
      open_r        <= 1'b0;
      alert_r       <= 1'b0;
      alert_out     <= 1'b0;
      alert_drive_n <= 1'b1;
    end else begin
      alert_out <= 1'b0;
      if (rate_cnt_r != 32'hffffffff)
        rate_cnt_r <= rate_cnt_r + 32'h1;
      if (conv_start) begin
        busy       <= 1'b1;
        conv_cnt_r <= 32'h0;
        rate_cnt_r <= 32'h0;
        oneshot_r  <= os_start;
        open_r     <= open_s;
      end else if (conv_abort) begin
        busy      <= 1'b0;
        oneshot_r <= 1'b0;
      end else if (conv_done) begin
        busy          <= 1'b0;
        oneshot_r     <= 1'b0;
        local_temp_r  <= loc_new;
        remote_temp_r <= rem_new;
      end else if (busy) begin
        conv_cnt_r <= conv_cnt_r + 32'h1;
      end
      if (wr_stb_r) begin
        case (cmd_r)
          `CMD_WR_CONFIG:   config_r   <= {wr_data_r[7:6], 6'h00};
          `CMD_WR_RATE:     rate_r     <= wr_data_r;
          `CMD_WR_LOC_HIGH: loc_high_r <= wr_data_r;
          `CMD_WR_LOC_LOW:  loc_low_r  <= wr_data_r;
          `CMD_WR_REM_HIGH: rem_high_r <= wr_data_r;
          `CMD_WR_REM_LOW:  rem_low_r  <= wr_data_r;
          default: ;
        endcase
      end
      // set wins over the clear of a status read
      if (stat_clr_stb_r)
        flags_r <= cond_now | set_vec;
      else
        flags_r <= flags_r | set_vec;
      if (|(set_vec & {5{~config_r[`CFG_MASK_BIT]}}))
        alert_r <= 1'b1;
      else if (ara_ok_stb_r)
        alert_r <= 1'b0;
      alert_drive_n <= ~((|(set_vec & {5{~config_r[`CFG_MASK_BIT]}})) |
                         (alert_r & ~ara_ok_stb_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address straps caught a few cycles after reset release

  always @(posedge clk) begin
    if (reset) begin
      strap_cnt_r <= 3'h0;
      own_addr_r  <= `SLAVE_ADDR_BASE;
    end else if (strap_cnt_r != `STRAP_WAIT) begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
      if (strap_cnt_r == `STRAP_WAIT - 3'h1)
        own_addr_r <= `SLAVE_ADDR_BASE | {5'h00, strap1_s, strap0_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial slave

  reg  [2:0] st_r;
  reg  [2:0] after_r;
  reg  [1:0] kind_r;
  reg  [3:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] tx_r;
  reg        tx_stat_r;
  reg        tx_ara_r;
  reg        scl_d_r;
  reg        sda_d_r;

  wire scl_rise   = scl_s & ~scl_d_r;
  wire scl_fall   = ~scl_s & scl_d_r;
  wire start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always @(posedge clk) begin
    wr_stb_r       <= 1'b0;
    oneshot_stb_r  <= 1'b0;
    stat_clr_stb_r <= 1'b0;
    ara_ok_stb_r   <= 1'b0;
    if (reset) begin
      st_r        <= S_IDLE;
      after_r     <= S_WAIT;
      kind_r      <= K_ADDR;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      tx_stat_r   <= 1'b0;
      tx_ara_r    <= 1'b0;
      cmd_r       <= `RST_COMMAND;
      wr_data_r   <= 8'h00;
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      sda_out     <= 1'b0;
      sda_drive_n <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      sda_out <= 1'b0;
      if (start_cond) begin
        st_r        <= S_RX;
        kind_r      <= K_ADDR;
        bit_cnt_r   <= 4'h0;
        sda_drive_n <= 1'b1;
      end else if (stop_cond) begin
        st_r        <= S_IDLE;
        sda_drive_n <= 1'b1;
      end else begin
        case (st_r)
          S_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r   <= 4'h0;
              st_r        <= S_ACK;
              sda_drive_n <= 1'b0;
              case (kind_r)
                K_ADDR: begin
                  if (shift_r[7:1] == own_addr_r) begin
                    if (shift_r[0]) begin
                      after_r   <= S_TX;
                      tx_r      <= read_mux;
                      tx_stat_r <= (cmd_r == `CMD_RD_STATUS);
                      tx_ara_r  <= 1'b0;
                    end else begin
                      after_r <= S_RX;
                      kind_r  <= K_CMD;
                    end
                  end else if (shift_r[7:1] == `ALERT_RESP_ADDR &&
                               shift_r[0] && alert_r) begin
                    after_r   <= S_TX;
                    tx_r      <= {own_addr_r, 1'b1};
                    tx_stat_r <= 1'b0;
                    tx_ara_r  <= 1'b1;
                  end else begin
                    st_r        <= S_WAIT;
                    sda_drive_n <= 1'b1;
                  end
                end
                K_CMD: begin
                  cmd_r   <= shift_r;
                  kind_r  <= K_DATA;
                  after_r <= S_RX;
                  if (shift_r == `CMD_ONE_SHOT)
                    oneshot_stb_r <= 1'b1;
                end
                default: begin
                  wr_stb_r  <= 1'b1;
                  wr_data_r <= shift_r;
                  after_r   <= S_WAIT;
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              st_r <= after_r;
              if (after_r == S_TX)
                sda_drive_n <= tx_r[7];
              else
                sda_drive_n <= 1'b1;
            end
          end
          S_TX: begin
            if (scl_rise) begin
              if (sda_drive_n && ~sda_s) begin
                // lost arbitration: stay silent, keep the alert
                st_r        <= S_WAIT;
                sda_drive_n <= 1'b1;
              end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end else if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                bit_cnt_r   <= 4'h0;
                st_r        <= S_TXACK;
                sda_drive_n <= 1'b1;
              end else begin
                tx_r        <= {tx_r[6:0], 1'b0};
                sda_drive_n <= tx_r[6];
              end
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              stat_clr_stb_r <= tx_stat_r;
              ara_ok_stb_r   <= tx_ara_r;
              st_r           <= S_WAIT;
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule

// ==== core/temp_sensor_regs.vh ====
`ifndef TEMP_SENSOR_REGS_VH
`define TEMP_SENSOR_REGS_VH

////////////////////////////////////////////////////////////////////////////
// command bytes
`define CMD_RD_LOCAL       8'h00
`define CMD_RD_REMOTE      8'h01
`define CMD_RD_STATUS      8'h02
`define CMD_RD_CONFIG      8'h03
`define CMD_RD_RATE        8'h04
`define CMD_RD_LOC_HIGH    8'h05
`define CMD_RD_LOC_LOW     8'h06
`define CMD_RD_REM_HIGH    8'h07
`define CMD_RD_REM_LOW     8'h08
`define CMD_WR_CONFIG      8'h09
`define CMD_WR_RATE        8'h0a
`define CMD_WR_LOC_HIGH    8'h0b
`define CMD_WR_LOC_LOW     8'h0c
`define CMD_WR_REM_HIGH    8'h0d
`define CMD_WR_REM_LOW     8'h0e
`define CMD_ONE_SHOT       8'h0f

////////////////////////////////////////////////////////////////////////////
// bit positions
`define CFG_MASK_BIT       7
`define CFG_HALT_BIT       6
`define STAT_BUSY_BIT      7

////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_TEMP           8'h00
`define RST_CONFIG         8'h00
`define RST_RATE           8'h02
`define RST_HIGH_LIMIT     8'h7f
`define RST_LOW_LIMIT      8'hc9
`define RST_COMMAND        8'h00
`define RATE_MAX           8'h07

////////////////////////////////////////////////////////////////////////////
// addresses; base value is arbitrary, straps fill the low two bits
`define ALERT_RESP_ADDR    7'h0c
`define SLAVE_ADDR_BASE    7'h18

////////////////////////////////////////////////////////////////////////////
// timing
`define CLK_FREQ_HZ        20000000
`define CONV_TIME_MS       125
`define CONV_CYCLES        (`CONV_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define RATE_BASE_S        16
`define RATE_BASE_CYCLES   (`RATE_BASE_S * `CLK_FREQ_HZ)
`define STRAP_WAIT         3'h6

`endif

// ==== test/smb_master.sv ====
`timescale 1ns/10ps
module smb_master (
  input  wire clk,
  input  wire sda_drive_n,
  input  wire sda_out,
  output reg  scl,
  output wire sda
);
  reg     sda_m = 1'b1;
  integer hp = 10;
  // pulled-up wire shared with the slave
  assign sda = sda_m & (sda_drive_n | sda_out);
  initial scl = 1'b1;
  task w(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task bitx(input b, output r);
    w(hp / 2);
    sda_m <= b;
    w(hp / 2);
    scl <= 1'b1;
    w(hp / 2);
    r = sda;
    w(hp / 2);
    scl <= 1'b0;
  endtask
  task bytex(input [8:0] d, output [8:0] r);
    integer i;
    for (i = 8; i >= 0; i = i - 1)
      bitx(d[i], r[i]);
  endtask
  task start;
    w(hp / 2);
    sda_m <= 1'b1;
    w(hp / 2);
    scl <= 1'b1;
    w(hp);
    sda_m <= 1'b0;
    w(hp);
    scl <= 1'b0;
  endtask
  ////////////////////////////////////////
  // k: 0 write, 1 read, 2 send, 3 receive; n counts missing acks
  task xact(input [1:0] k, input [6:0] a, input [7:0] c,
            input [7:0] d, output [7:0] q, output [1:0] n);
    reg [8:0] r;
    q = 8'hff;
    start;
    bytex({a, k == 2'h3, 1'b1}, r);
    n = {1'b0, r[0]};
    if (k != 2'h3) begin
      bytex({c, 1'b1}, r);
      n = n + r[0];
    end
    if (k == 2'h0) begin
      bytex({d, 1'b1}, r);
      n = n + r[0];
    end
    if (k == 2'h1) begin
      start;
      bytex({a, 2'h3}, r);
      n = n + r[0];
    end
    if (k[0]) begin
      bytex(9'h1ff, r);
      q = r[8:1];
    end
    w(hp / 2);
    sda_m <= 1'b0;
    w(hp / 2);
    scl <= 1'b1;
    w(hp);
    sda_m <= 1'b1;
    w(hp);
  endtask
endmodule

// ==== test/tb_temp_sensor_ctrl.sv ====
`timescale 1ns/10ps
`include "temp_sensor_regs.vh"
`define CHK(nm, e, g) begin tests_run = tests_run + 1; \
  if ((g) !== (e)) begin failures = failures + 1; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_temp_sensor_ctrl;
  localparam [63:0] RV = 64'h00_00_c9_7f_c9_7f_02_00;
  localparam [95:0] CV = 96'hc00_3ff_ee8_f9a_ffd_ffe_002_1fa;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         standby_pin_n_n = 1'b1;
  reg         d_open = 1'b0;
  reg         r_short = 1'b0;
  reg  [1:0]  strap = 2'h0;
  reg  [10:0] lq = 11'h000;
  reg  [10:0] rq = 11'h000;
  reg  [10:0] t;
  reg  [31:0] seed = 32'h00014ee0;
  reg  [7:0]  q;
  reg  [7:0]  v;
  reg  [1:0]  n;
  integer     failures = 0;
  integer     tests_run = 0;
  integer     i;
  wire        scl, sda, sdo, sdn, adn, busy;
  wire [6:0]  sa = `SLAVE_ADDR_BASE | {5'h00, strap};
  always #25 clk = ~clk;
  temp_sensor_ctrl #(.CONV_CYCLES(200), .RATE_BASE_CYCLES(400000)) DUT (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
    .sda_drive_n(sdn), .alert_out(), .alert_drive_n(adn),
    .standby_pin_n(standby_pin_n_n), .address_strap_0(strap[0]),
    .address_strap_1(strap[1]), .diode_open(d_open),
    .remote_short(r_short), .local_temp_quarter(lq),
    .remote_temp_quarter(rq), .busy(busy));
  smb_master m (.clk(clk), .sda_drive_n(sdn), .sda_out(sdo), .scl(scl),
    .sda(sda));
  ////////////////////////////////////////
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // quarter degrees to rounded, clamped whole degrees
  function [7:0] enc(input [10:0] x);
    integer s;
    s = ($signed(x) + 2) >>> 2;
    if (s > 127) s = 127;
    if (s < -65) s = -65;
    enc = s[7:0];
  endfunction
  task summarize;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task x(input [1:0] k, input [7:0] c, input [7:0] d);
    m.xact(k, sa, c, d, q, n);
    `CHK("ack", 2'h0, n)
  endtask
  task rd(input [7:0] c, input [7:0] e);
    x(2'h1, c, 8'h00);
    `CHK("data", e, q)
  endtask
  task wt(input b);
    integer j;
    for (j = 0; j < 400 && busy !== b; j = j + 1)
      @(posedge clk);
    if (busy !== b) begin
      failures = failures + 1;
      summarize;
    end
  endtask
  task shot(input [7:0] e);
    wt(1'b0);
    x(2'h2, `CMD_ONE_SHOT, 8'h00);
    wt(1'b1);
    wt(1'b0);
    rd(`CMD_RD_LOCAL, e);
  endtask
  ////////////////////////////////////////
  initial begin
    seed = nxt(seed);
    strap <= seed[7:6];
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    for (i = 0; i < 8; i = i + 1)
      rd(i[7:0] + 8'h03, RV[i*8 +: 8]);
    m.hp = 20;
    m.xact(2'h1, sa ^ 7'h40, 8'h05, 8'h00, q, n);
    `CHK("nack", 2'h3, n)
    m.hp = 10;
    for (i = 0; i < 8; i = i + 1) begin
      seed = nxt(seed);
      v = {i[0], seed[6:0] | {6'h00, ~i[0]}};
      x(2'h0, 8'h0b + i[1:0], v);
      rd(8'h05 + i[1:0], v);
      x(2'h3, 8'h00, 8'h00);
      `CHK("recv", v, q)
    end
    for (i = 0; i < 14; i = i + 1) begin
      seed = nxt(seed);
      t = i < 8 ? CV[i*12 +: 11] : seed[10:0];
      lq <= t;
      rq <= ~t;
      shot(enc(t));
      rd(`CMD_RD_REMOTE, enc(~t));
      if (i == 0) `CHK("alarm", 1'b0, adn)
    end
    lq <= 11'h000;
    rq <= 11'h000;
    shot(8'h00);
    x(2'h1, `CMD_RD_STATUS, 8'h00);
    x(2'h1, `CMD_RD_STATUS, 8'h00);
    `CHK("flags", 8'h00, q & 8'h7f)
    `CHK("latch", 1'b0, adn)
    m.xact(2'h3, `ALERT_RESP_ADDR, 8'h00, 8'h00, q, n);
    `CHK("reply", {sa, 1'b1}, q)
    `CHK("clear", 1'b1, adn)
    d_open <= 1'b1;
    r_short <= 1'b1;
    rq <= 11'h0a0;
    shot(8'h00);
    rd(`CMD_RD_REMOTE, 8'h00);
    rd(`CMD_RD_STATUS, 8'h04);
    d_open <= 1'b0;
    r_short <= 1'b0;
    standby_pin_n_n <= 1'b0;
    lq <= 11'h040;
    repeat (10) @(posedge clk);
    x(2'h2, `CMD_ONE_SHOT, 8'h00);
    repeat (100) @(posedge clk);
    `CHK("hw standby_pin_n", 1'b0, busy)
    rd(`CMD_RD_LOCAL, 8'h00);
    standby_pin_n_n <= 1'b1;
    repeat (10) @(posedge clk);
    x(2'h2, `CMD_ONE_SHOT, 8'h00);
    `CHK("run", 1'b1, busy)
    standby_pin_n_n <= 1'b0;
    wt(1'b0);
    rd(`CMD_RD_LOCAL, 8'h00);
    standby_pin_n_n <= 1'b1;
    x(2'h0, `CMD_WR_CONFIG, 8'hc0);
    rd(`CMD_RD_CONFIG, 8'hc0);
    x(2'h0, `CMD_WR_RATE, 8'h05);
    rd(`CMD_RD_RATE, 8'h05);
    m.xact(2'h3, `ALERT_RESP_ADDR, 8'h00, 8'h00, q, n);
    `CHK("reply", {sa, 1'b1}, q)
    lq <= 11'h1fc;
    shot(8'h7f);
    `CHK("mask", 1'b1, adn)
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    rd(`CMD_RD_LOC_HIGH, 8'h7f);
    rd(`CMD_RD_CONFIG, 8'h00);
    rd(`CMD_RD_RATE, 8'h02);
    summarize;
  end
endmodule

// ==== test/temp_sensor_ctrl_chk.sv ====
`timescale 1ns/10ps
module temp_sensor_ctrl_chk #(
  parameter CONV_CYCLES      = 200,
  parameter RATE_BASE_CYCLES = 800
) (
  input wire        clk,
  input wire        reset,
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_drive_n,
  input wire        alert_out,
  input wire        alert_drive_n,
  input wire        standby_pin_n,
  input wire        address_strap_0,
  input wire        address_strap_1,
  input wire        diode_open,
  input wire        remote_short,
  input wire [10:0] local_temp_quarter,
  input wire [10:0] remote_temp_quarter,
  input wire        busy
);
  // cycles of the current busy run
  reg  [31:0] run_r;
  wire [31:0] run_nxt = (reset || !busy) ? 32'h0 : run_r + 32'h1;
  always @(posedge clk) begin
    run_r <= run_nxt;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  sequence s_standby_pin_n_low;
    !standby_pin_n [*6];
  endsequence
  sequence s_scl_fell;
    !scl_in && !$past(scl_in, 2) && $past(scl_in, 8);
  endsequence
  sequence s_scl_rose;
    scl_in && $past(scl_in, 2) && !$past(scl_in, 8);
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    reset |=> sda_drive_n && alert_drive_n && !busy)
    else $error("outputs not idle after reset");
  a_outs_low: assert property (!sda_out && !alert_out)
    else $error("open drain value not zero");
  a_drive_scl_low: assert property (
    $changed(sda_drive_n) |-> s_scl_fell)
    else $error("data line moved outside clock low");
  a_standby_pin_n_halt: assert property (s_standby_pin_n_low |-> !busy)
    else $error("busy while standby pin low");
  a_conv_len: assert property (run_r <= CONV_CYCLES)
    else $error("conversion too long");
  a_start_conv: assert property ($fell(reset) |=> busy)
    else $error("no conversion after reset");
  a_alert_clear: assert property (
    $rose(alert_drive_n) |-> s_scl_rose)
    else $error("alert released without reply");
  a_busy_gap: assert property ($fell(busy) |=> !busy [*2])
    else $error("no idle gap after conversion");
endmodule
bind temp_sensor_ctrl temp_sensor_ctrl_chk #(
  .CONV_CYCLES      (CONV_CYCLES),
  .RATE_BASE_CYCLES (RATE_BASE_CYCLES)
) chk (
  .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_drive_n(sda_drive_n), .alert_out(alert_out),
  .alert_drive_n(alert_drive_n), .standby_pin_n(standby_pin_n),
  .address_strap_0(address_strap_0), .address_strap_1(address_strap_1),
  .diode_open(diode_open), .remote_short(remote_short),
  .local_temp_quarter(local_temp_quarter),
  .remote_temp_quarter(remote_temp_quarter), .busy(busy)
);
